//--- hdl/srcr_pkg.sv
// Purpose: shared constants and types of the receiver status calendar registers
// Assumes: word-indexed register port, 16-bit data
// Notes: every offset, field position and latency figure lives here
package srcr_pkg;
	// register indices on the slave port
	localparam logic [3:0] ADR_IDENT = 4'h0;
	localparam logic [3:0] ADR_CTL = 4'h1;
	localparam logic [3:0] ADR_MUL0 = 4'h2;
	localparam logic [3:0] ADR_MUL1 = 4'h3;
	localparam logic [3:0] ADR_LEN0 = 4'h4;
	localparam logic [3:0] ADR_LEN1 = 4'h5;
	localparam logic [3:0] ADR_PTR = 4'h6;
	localparam logic [3:0] ADR_DAT0 = 4'h7;
	localparam logic [3:0] ADR_DAT1 = 4'h8;
	// control register bit positions
	localparam int CTL_REPOS_EN = 0;
	localparam int CTL_FORCE = 1;
	localparam int CTL_SEL_REQ = 2;
	localparam int CTL_SEL_ACT = 3;
	localparam int CTL_OFF = 5;
	localparam logic [5:0] CTL_RST = 6'h02;
	// identity field split
	localparam int CODE_W = 13;
	localparam int KIND_W = 3;
	// field widths
	localparam int DW = 16;
	localparam int CAL_AW = 10;
	localparam int CAL_DW = 8;
	localparam int MUL_W = 8;
	localparam int LEN_W = 10;
	// two-bit words on the status channel
	localparam logic [1:0] SEL_WORD0 = 2'h1;
	localparam logic [1:0] SEL_WORD1 = 2'h2;
	localparam logic [1:0] FRAMING_WORD = 2'h3;
	// latency figures in byte times
	localparam int STATUS_LAT_BYTES = 320;
	localparam int LAT128_SHARED = 272;
	localparam int LAT128_PORT = 288;
	localparam int LAT64_SHARED = 152;
	localparam int LAT64_PORT = 160;
	localparam int LAT32_SHARED = 36;
	localparam int LAT32_PORT = 72;
	localparam int PHASE128 = 32;
	localparam int PHASE64 = 16;
	localparam int PHASE64_OLD = 24;
	localparam int EXT128 = 8;
	localparam int EXT64 = 4;
	localparam int EXT32 = 2;
	// register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [15:0] wdata;
	} srcr_req_t;
	// settings handed to the status frame generator
	typedef struct packed {
		logic sel_en;
		logic framing;
		logic [1:0] sel_word;
		logic [7:0] mul;
		logic [9:0] len;
	} srcr_cfg_t;
	// status transmit state
	typedef enum logic [1:0] {
		SRCR_RUN = 2'b01,
		SRCR_FRAME = 2'b10
	} srcr_st_t;
endpackage

//--- hdl/srcr_regs.sv
// Purpose: control and status registers plus calendar memories of the receiver
// Assumes: single clock i_mclk, synchronous active-low reset, same-domain inputs
// Notes: read data answers one cycle after the read strobe
`timescale 1ns/1ps
module srcr_regs #(
	parameter int DATA_W = 128,
	parameter bit SHARED_BUF = 1'b1,
	parameter bit PHASE_EN = 1'b0,
	parameter bit OLD_XCVR = 1'b0,
	parameter logic [12:0] CORE_CODE = 13'h0123, // arbitrary value
	parameter logic [2:0] UNIT_KIND = 3'h1, // arbitrary value
	parameter int STAT_W = 10
) (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire srcr_pkg::srcr_req_t i_req,
	input wire logic i_force_framing_input,
	input wire logic i_status_channel_off_flag,
	input wire logic i_frame_boundary,
	input wire logic [9:0] i_cal_rd_addr,
	input wire logic i_stat_valid,
	input wire logic [STAT_W-1:0] i_stat,
	output logic [15:0] o_rdata,
	output logic o_rvalid,
	output srcr_pkg::srcr_cfg_t o_cfg,
	output logic [7:0] o_cal_entry,
	output logic o_stat_valid,
	output logic [STAT_W-1:0] o_stat,
	output logic [9:0] o_data_lat_bytes
);
	// bytes moved per clock and derived status delay in cycles
	localparam int BPC = DATA_W / 8;
	localparam int STAT_CYC_RAW = srcr_pkg::STATUS_LAT_BYTES / BPC;
	localparam int STAT_CYC = (STAT_CYC_RAW < 1) ? 1 : STAT_CYC_RAW;
	localparam int DEPTH = 1 << srcr_pkg::CAL_AW;

	// data latency figure for this build, pins to buffer write side
	function automatic int data_lat();
		int l;
		l = 0;
		if (DATA_W == 128) begin
			l = SHARED_BUF ? srcr_pkg::LAT128_SHARED : srcr_pkg::LAT128_PORT;
			l += PHASE_EN ? srcr_pkg::PHASE128 : 0;
			l += SHARED_BUF ? srcr_pkg::EXT128 : 0;
		end else if (DATA_W == 64) begin
			l = SHARED_BUF ? srcr_pkg::LAT64_SHARED : srcr_pkg::LAT64_PORT;
			l += PHASE_EN ? srcr_pkg::PHASE64 : 0;
			l += (PHASE_EN && OLD_XCVR) ? srcr_pkg::PHASE64_OLD : 0;
			l += SHARED_BUF ? srcr_pkg::EXT64 : 0;
		end else begin
			l = SHARED_BUF ? srcr_pkg::LAT32_SHARED : srcr_pkg::LAT32_PORT;
			l += SHARED_BUF ? srcr_pkg::EXT32 : 0;
		end
		return l;
	endfunction

	// is this index a live register, given the repositioning enable
	function automatic logic addr_live(input logic [3:0] a, input logic en);
		logic set1;
		set1 = (a == srcr_pkg::ADR_MUL1) || (a == srcr_pkg::ADR_LEN1) ||
			(a == srcr_pkg::ADR_DAT1);
		return (a <= srcr_pkg::ADR_DAT1) && (en || !set1);
	endfunction

	// software-visible state
	logic [5:0] ctl_r, ctl_nxt; // control/status word, bit 4 stays zero
	logic [7:0] mul0_r, mul0_nxt, mul1_r, mul1_nxt;
	logic [9:0] len0_r, len0_nxt, len1_r, len1_nxt;
	logic [9:0] ptr_r, ptr_nxt; // indirect memory pointer
	logic [15:0] rdata_nxt;
	logic rvalid_nxt;
	logic [7:0] ram0 [DEPTH]; // calendar entries, set 0
	logic [7:0] ram1 [DEPTH]; // calendar entries, set 1
	logic we0, we1;
	logic wr_ok, rd_ok, force_eff;
	srcr_pkg::srcr_st_t st_r, st_nxt;
	srcr_pkg::srcr_cfg_t cfg_nxt;
	logic [7:0] entry_nxt;
	logic [STAT_W:0] pipe_r [STAT_CYC]; // status delay line, valid on top
	logic [STAT_W:0] pipe_nxt [STAT_CYC];

	// effective forcing combines software bit and pin
	assign force_eff = ctl_r[srcr_pkg::CTL_FORCE] | i_force_framing_input;
	assign wr_ok = i_req.wr && addr_live(i_req.addr, ctl_r[srcr_pkg::CTL_REPOS_EN]);
	assign rd_ok = addr_live(i_req.addr, ctl_r[srcr_pkg::CTL_REPOS_EN]);

	// register writes, active select capture and off mirror
	always_comb begin
		ctl_nxt = ctl_r;
		mul0_nxt = mul0_r;
		mul1_nxt = mul1_r;
		len0_nxt = len0_r;
		len1_nxt = len1_r;
		ptr_nxt = ptr_r;
		we0 = 1'b0;
		we1 = 1'b0;
		if (wr_ok) begin
			// edit-while-idle is left to software; the bank does not police it
			unique case (i_req.addr)
				srcr_pkg::ADR_CTL: begin
					// only writable bits; read-only ones are kept
					ctl_nxt[srcr_pkg::CTL_REPOS_EN] = i_req.wdata[srcr_pkg::CTL_REPOS_EN];
					ctl_nxt[srcr_pkg::CTL_FORCE] = i_req.wdata[srcr_pkg::CTL_FORCE];
					ctl_nxt[srcr_pkg::CTL_SEL_REQ] = i_req.wdata[srcr_pkg::CTL_SEL_REQ];
				end
				srcr_pkg::ADR_MUL0: mul0_nxt = i_req.wdata[7:0];
				srcr_pkg::ADR_MUL1: mul1_nxt = i_req.wdata[7:0];
				srcr_pkg::ADR_LEN0: len0_nxt = i_req.wdata[9:0];
				srcr_pkg::ADR_LEN1: len1_nxt = i_req.wdata[9:0];
				srcr_pkg::ADR_PTR: ptr_nxt = i_req.wdata[9:0];
				srcr_pkg::ADR_DAT0: we0 = 1'b1;
				srcr_pkg::ADR_DAT1: we1 = 1'b1;
				default: ; // identity index: read only
			endcase
		end
		// new select word only at a frame edge
		if (i_frame_boundary) begin
			ctl_nxt[srcr_pkg::CTL_SEL_ACT] = ctl_r[srcr_pkg::CTL_SEL_REQ];
		end
		ctl_nxt[4] = 1'b0;
		ctl_nxt[srcr_pkg::CTL_OFF] = i_status_channel_off_flag;
	end

	// read answer, one cycle after the strobe
	always_comb begin
		rdata_nxt = '0;
		rvalid_nxt = i_req.rd;
		if (i_req.rd && rd_ok) begin
			unique case (i_req.addr)
				srcr_pkg::ADR_IDENT: rdata_nxt = {UNIT_KIND, CORE_CODE};
				srcr_pkg::ADR_CTL: rdata_nxt = {10'h000, ctl_r};
				srcr_pkg::ADR_MUL0: rdata_nxt = {8'h00, mul0_r};
				srcr_pkg::ADR_MUL1: rdata_nxt = {8'h00, mul1_r};
				srcr_pkg::ADR_LEN0: rdata_nxt = {6'h00, len0_r};
				srcr_pkg::ADR_LEN1: rdata_nxt = {6'h00, len1_r};
				srcr_pkg::ADR_PTR: rdata_nxt = {6'h00, ptr_r};
				srcr_pkg::ADR_DAT0: rdata_nxt = {8'h00, ram0[ptr_r]};
				srcr_pkg::ADR_DAT1: rdata_nxt = {8'h00, ram1[ptr_r]};
				default: rdata_nxt = '0;
			endcase
		end
	end

	// status state machine: run, or send framing continuously
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			srcr_pkg::SRCR_RUN: if (force_eff && i_frame_boundary) st_nxt = srcr_pkg::SRCR_FRAME;
			srcr_pkg::SRCR_FRAME: if (!force_eff) st_nxt = srcr_pkg::SRCR_RUN;
			default: st_nxt = srcr_pkg::SRCR_FRAME; // illegal code: safe side
		endcase
	end

	// settings and active calendar entry for the frame generator
	always_comb begin
		logic act;
		act = ctl_r[srcr_pkg::CTL_SEL_ACT];
		cfg_nxt.sel_en = ctl_r[srcr_pkg::CTL_REPOS_EN];
		cfg_nxt.framing = (st_r == srcr_pkg::SRCR_FRAME);
		cfg_nxt.sel_word = (st_r == srcr_pkg::SRCR_FRAME) ? srcr_pkg::FRAMING_WORD :
			(act ? srcr_pkg::SEL_WORD1 : srcr_pkg::SEL_WORD0);
		cfg_nxt.mul = act ? mul1_r : mul0_r;
		cfg_nxt.len = act ? len1_r : len0_r;
		entry_nxt = act ? ram1[i_cal_rd_addr] : ram0[i_cal_rd_addr];
	end

	// status delay line; its depth sets the transmit latency
	always_comb begin
		pipe_nxt[0] = {i_stat_valid, i_stat};
		for (int i = 1; i < STAT_CYC; i++) begin
			pipe_nxt[i] = pipe_r[i-1];
		end
	end

	// registers only
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			ctl_r <= srcr_pkg::CTL_RST;
			mul0_r <= '0;
			mul1_r <= '0;
			len0_r <= '0;
			len1_r <= '0;
			ptr_r <= '0;
			o_rdata <= '0;
			o_rvalid <= 1'b0;
			st_r <= srcr_pkg::SRCR_FRAME;
			o_cfg <= '0;
			o_cal_entry <= '0;
			o_data_lat_bytes <= '0;
			for (int i = 0; i < STAT_CYC; i++) begin
				pipe_r[i] <= '0;
			end
		end else begin
			ctl_r <= ctl_nxt;
			mul0_r <= mul0_nxt;
			mul1_r <= mul1_nxt;
			len0_r <= len0_nxt;
			len1_r <= len1_nxt;
			ptr_r <= ptr_nxt;
			o_rdata <= rdata_nxt;
			o_rvalid <= rvalid_nxt;
			st_r <= st_nxt;
			o_cfg <= cfg_nxt;
			o_cal_entry <= entry_nxt;
			o_data_lat_bytes <= 10'(data_lat());
			pipe_r <= pipe_nxt;
		end
	end

	// memories carry no reset; contents are software's to load
	always_ff @(posedge i_mclk) begin
		if (we0) begin
			ram0[ptr_r] <= i_req.wdata[7:0];
		end
		if (we1) begin
			ram1[ptr_r] <= i_req.wdata[7:0];
		end
	end

	assign o_stat_valid = pipe_r[STAT_CYC-1][STAT_W];
	assign o_stat = pipe_r[STAT_CYC-1][STAT_W-1:0];

	// checks
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);

	sequence s_run_edge;
		st_r == srcr_pkg::SRCR_RUN && force_eff && i_frame_boundary;
	endsequence
	sequence s_in_frame;
		st_r == srcr_pkg::SRCR_FRAME;
	endsequence

	// write lands in ctl_r, then o_cfg one edge later: seen at the third edge
	chk_sel_enable: assert property (
		i_req.wr && i_req.addr == srcr_pkg::ADR_CTL |-> ##3 o_cfg.sel_en == $past(i_req.wdata[0], 3))
		else $error("select word enable did not follow control write");
	chk_frame_start: assert property (
		s_run_edge |=> s_in_frame ##1 o_cfg.sel_word == srcr_pkg::FRAMING_WORD)
		else $error("forced framing did not start at boundary");
	chk_frame_end: assert property (
		s_in_frame and !force_eff |=> st_r == srcr_pkg::SRCR_RUN)
		else $error("framing did not stop after release");
	chk_pin_force: assert property (
		st_r == srcr_pkg::SRCR_RUN && i_force_framing_input && i_frame_boundary |=> s_in_frame)
		else $error("force input ignored");
	chk_reset_force: assert property (
		$rose(i_rst_b) |-> s_in_frame and ctl_r[srcr_pkg::CTL_FORCE])
		else $error("forcing bit not set out of reset");
	chk_sel_apply: assert property (
		i_frame_boundary |=> ctl_r[srcr_pkg::CTL_SEL_ACT] == $past(ctl_r[srcr_pkg::CTL_SEL_REQ]))
		else $error("select request not applied at boundary");
	chk_sel_hold: assert property (
		!i_frame_boundary |=> $stable(ctl_r[srcr_pkg::CTL_SEL_ACT]))
		else $error("active select moved off boundary");
	chk_set1_hidden: assert property (
		i_req.rd && i_req.addr == srcr_pkg::ADR_MUL1 && !ctl_r[0] |=> o_rvalid && o_rdata == 16'h0000)
		else $error("set1 readable while reserved");
	chk_mem_write: assert property (
		we0 |=> ram0[$past(ptr_r)] == $past(i_req.wdata[7:0]))
		else $error("calendar write lost");
	chk_mem_read: assert property (
		i_req.rd && i_req.addr == srcr_pkg::ADR_DAT1 && ctl_r[0] |=> o_rdata[7:0] == ram1[$past(ptr_r)])
		else $error("calendar read wrong");
	chk_stat_delay: assert property (
		i_stat_valid |-> ##STAT_CYC o_stat_valid && o_stat == $past(i_stat, STAT_CYC))
		else $error("status latency wrong");
	chk_res_zero: assert property (
		i_req.rd && i_req.addr > srcr_pkg::ADR_DAT1 |=> o_rvalid && o_rdata == 16'h0000)
		else $error("reserved index read nonzero");
	chk_res_write: assert property (
		i_req.wr && i_req.addr > srcr_pkg::ADR_DAT1 |=> $stable(mul0_r) && $stable(len0_r) && $stable(ptr_r))
		else $error("reserved index write changed a register");
	chk_set1_locked: assert property (
		i_req.wr && i_req.addr == srcr_pkg::ADR_MUL1 && !ctl_r[srcr_pkg::CTL_REPOS_EN] |=> $stable(mul1_r))
		else $error("set1 writable while reserved");
	// the mirror lags the flag by exactly one edge
	chk_off_mirror: assert property (
		1'b1 |=> ctl_r[srcr_pkg::CTL_OFF] == $past(i_status_channel_off_flag))
		else $error("off flag not mirrored");
	chk_read_pulse: assert property (
		1'b1 |=> o_rvalid == $past(i_req.rd))
		else $error("read answer not one cycle after strobe");
endmodule // srcr_regs

//--- test/srcr_frame_model.sv
// Purpose: stand-in for the status frame generator that marks frame edges
// Assumes: shares clock and reset with the register bank
// Notes: a fixed period keeps every bench wait short and bounded
`timescale 1ns/1ps
module srcr_frame_model #(
	parameter int PERIOD = 16
) (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	output logic o_frame_boundary
);
	logic [7:0] cnt_r; // cycles since the last frame edge
	logic [7:0] cnt_nxt; // next count
	// wrap at the period so the edge pulse is one cycle wide
	always_comb begin
		cnt_nxt = (cnt_r == 8'(PERIOD - 1)) ? 8'h00 : cnt_r + 8'h01;
	end
	// register only
	always_ff @(posedge i_mclk) begin
		cnt_r <= i_rst_b ? cnt_nxt : 8'h00;
	end
	assign o_frame_boundary = (cnt_r == 8'(PERIOD - 1));
endmodule // srcr_frame_model

//--- test/spi42_rx_status_calendar_regs_bench.sv
// Purpose: self-checking bench of the status calendar register bank
// Assumes: per-port buffers, 128-bit path, no phase alignment
// Notes: reset checks first, then table rows, framing, select and latency cases
`timescale 1ns/1ps
module spi42_rx_status_calendar_regs_bench;
	typedef struct packed {
		logic wr;
		logic [3:0] a;
		logic [15:0] d;
		logic [15:0] e;
	} srcr_row_t;
	logic i_mclk = 1'b0;
	logic i_rst_b = 1'b0; // held low for four cycles
	logic frc = 1'b0; // external forcing level
	logic off = 1'b0; // status channel off flag
	logic stv = 1'b0;
	logic [9:0] sti = 10'h000;
	logic [9:0] cra = 10'h000; // generator calendar read address
	srcr_pkg::srcr_req_t req = '0;
	logic [15:0] rdata;
	logic rvalid;
	srcr_pkg::srcr_cfg_t cfg;
	logic [7:0] ent;
	logic sov;
	logic [9:0] so;
	logic [9:0] lat;
	logic fb; // frame edge from the model
	logic [15:0] got; // last read answer
	int n_fail = 0;
	int n_tests = 0;
	int k;
	// write-then-read rows; reserved places must read zero
	srcr_row_t rows [8] = '{
		'{1'b1, srcr_pkg::ADR_MUL0, 16'hff12, 16'h0012},
		'{1'b1, srcr_pkg::ADR_LEN0, 16'hffff, 16'h03ff},
		'{1'b1, srcr_pkg::ADR_PTR, 16'h0155, 16'h0155},
		'{1'b1, srcr_pkg::ADR_MUL1, 16'h0055, 16'h0000},
		'{1'b1, srcr_pkg::ADR_DAT1, 16'h0033, 16'h0000},
		'{1'b1, 4'h9, 16'h1234, 16'h0000},
		'{1'b1, srcr_pkg::ADR_IDENT, 16'hffff, 16'h2123},
		'{1'b1, srcr_pkg::ADR_CTL, 16'h003a, 16'h0002}
	};
	always #5 i_mclk = ~i_mclk;
	srcr_regs #(.SHARED_BUF(1'b0), .CORE_CODE(13'h0123), .UNIT_KIND(3'h1)) dut_u (
		.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_req(req),
		.i_force_framing_input(frc), .i_status_channel_off_flag(off),
		.i_frame_boundary(fb), .i_cal_rd_addr(cra), .i_stat_valid(stv), .i_stat(sti),
		.o_rdata(rdata), .o_rvalid(rvalid), .o_cfg(cfg), .o_cal_entry(ent),
		.o_stat_valid(sov), .o_stat(so), .o_data_lat_bytes(lat));
	srcr_frame_model #(.PERIOD(16)) gen_u (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
		.o_frame_boundary(fb));
	// verdict in one place
	task automatic conclude();
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// inputs move 1 ns after the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		cyc(1);
		req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		cyc(1);
		req = '0;
	endtask
	// answer waited for under a small bound
	task automatic rd(input logic [3:0] a);
		int j;
		cyc(1);
		req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		cyc(1);
		req = '0;
		for (j = 0; j < 3 && rvalid !== 1'b1; j++) cyc(1);
		if (rvalid !== 1'b1) begin
			n_fail++;
			conclude();
		end
		got = rdata;
	endtask
	// settle past the next frame edge and the output lag
	task automatic wait_fb();
		int j;
		for (j = 0; j < 40 && fb !== 1'b1; j++) cyc(1);
		if (fb !== 1'b1) begin
			n_fail++;
			conclude();
		end
		cyc(4);
	endtask
	initial begin
		cyc(4);
		i_rst_b = 1'b1;
		rd(srcr_pkg::ADR_CTL);
		chk("ctl reset", 16'h0002, got);
		chk("framing at reset", 16'h0001, 16'(cfg.framing));
		chk("data latency", 16'h0120, 16'(lat));
		$display("test done: reset");
		for (int i = 0; i < 8; i++) begin
			if (rows[i].wr) begin
				wr(rows[i].a, rows[i].d);
			end
			rd(rows[i].a);
			chk("table row", rows[i].e, got);
		end
		$display("test done: table");
		wr(srcr_pkg::ADR_CTL, 16'h0000);
		cyc(2);
		chk("framing cleared", 16'h0000, 16'(cfg.framing));
		frc = 1'b1;
		wait_fb();
		chk("input forcing", 16'h0001, 16'(cfg.framing));
		chk("framing word", 16'h0003, 16'(cfg.sel_word));
		frc = 1'b0;
		cyc(3);
		chk("input release", 16'h0000, 16'(cfg.framing));
		wr(srcr_pkg::ADR_CTL, 16'h0002);
		wait_fb();
		chk("bit forcing", 16'h0001, 16'(cfg.framing));
		$display("test done: framing");
		wr(srcr_pkg::ADR_CTL, 16'h0001);
		wr(srcr_pkg::ADR_MUL1, 16'h0077);
		wr(srcr_pkg::ADR_LEN1, 16'h0105);
		rd(srcr_pkg::ADR_MUL1);
		chk("set1 open", 16'h0077, got);
		wr(srcr_pkg::ADR_CTL, 16'h0005);
		wait_fb();
		rd(srcr_pkg::ADR_CTL);
		chk("select active", 16'h000d, got);
		chk("select word 1", 16'h0002, 16'(cfg.sel_word));
		chk("word enabled", 16'h0001, 16'(cfg.sel_en));
		chk("active mul", 16'h0077, 16'(cfg.mul));
		chk("active len", 16'h0105, 16'(cfg.len));
		wr(srcr_pkg::ADR_PTR, 16'h0005);
		wr(srcr_pkg::ADR_DAT0, 16'h00aa);
		wr(srcr_pkg::ADR_PTR, 16'h0006);
		wr(srcr_pkg::ADR_DAT0, 16'h00bb);
		wr(srcr_pkg::ADR_PTR, 16'h0005);
		rd(srcr_pkg::ADR_DAT0);
		chk("memory read", 16'h00aa, got);
		wr(srcr_pkg::ADR_CTL, 16'h0001);
		wait_fb();
		chk("select word 0", 16'h0001, 16'(cfg.sel_word));
		wr(srcr_pkg::ADR_DAT1, 16'h00cc);
		rd(srcr_pkg::ADR_DAT1);
		chk("set1 memory", 16'h00cc, got);
		cra = 10'h005;
		cyc(2);
		chk("calendar entry", 16'h00aa, 16'(ent));
		wr(srcr_pkg::ADR_CTL, 16'h0000);
		cyc(3);
		chk("word disabled", 16'h0000, 16'(cfg.sel_en));
		$display("test done: select");
		off = 1'b1;
		cyc(2);
		rd(srcr_pkg::ADR_CTL);
		chk("off mirror", 16'h0020, got);
		off = 1'b0;
		stv = 1'b1;
		sti = 10'h2a5;
		cyc(1);
		stv = 1'b0;
		sti = 10'h000;
		for (k = 0; k < 40 && sov !== 1'b1; k++) cyc(1);
		// 16 bytes a clock; the count starts at the capture edge
		chk("status delay", 16'(srcr_pkg::STATUS_LAT_BYTES / 16 - 1), 16'(k));
		chk("status value", 16'h02a5, 16'(so));
		$display("test done: latency");
		conclude();
	end
endmodule // spi42_rx_status_calendar_regs_bench
